// [core/rtcdc_pkg.sv]
// Package: constants for the divider chain real time clock
package rtcdc_pkg;
  localparam int unsigned PRESCALE_W = 16;
  localparam int unsigned SEG0_W = 10;
  localparam int unsigned SEG1_W = 6;
  localparam int unsigned SEG2_W = 6;
  localparam int unsigned SEG3_W = 10;
  localparam int unsigned COUNT_W = 32;
  localparam int unsigned WIDE_W = 48;
  localparam int unsigned SEG1_LSB = 10;
  localparam int unsigned SEG2_LSB = 16;
  localparam int unsigned SEG3_LSB = 22;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned SRC_W = 4;
  localparam int unsigned NUM_REQ = 6;
  // Fixed divider ratios and counter widths
  localparam logic [4:0] DIV32_LAST = 5'h1f;
  localparam logic [2:0] DIV8_LAST = 3'h7;
  // Request flag positions
  localparam int unsigned REQ_PRESCALE = 0;
  localparam int unsigned REQ_SEG0 = 1;
  localparam int unsigned REQ_SEG1 = 2;
  localparam int unsigned REQ_SEG2 = 3;
  localparam int unsigned REQ_SEG3 = 4;
  localparam int unsigned REQ_ALARM = 5;
  // Reset values
  localparam logic [PRESCALE_W-1:0] PRESCALE_RST = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_RST = 32'h0000_0000;
  localparam logic [NUM_REQ-1:0] REQ_RST = 6'h00;
endpackage : rtcdc_pkg

// [core/rtcdc_core.sv]
// Real time clock built as a chain of up-counting divider stages

module rtcdc_core (
  // Clock and power reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Counting clock sources, sampled as ordinary inputs
  input wire logic [rtcdc_pkg::SRC_W-1:0] src_tick,
  input wire logic [1:0] src_sel,
  input wire logic run_en,
  // Fixed divider bypass controls
  input wire logic div32_en,
  input wire logic div8_en,
  // Prescale timer access
  input wire logic prescale_wr,
  input wire logic [rtcdc_pkg::PRESCALE_W-1:0] prescale_wdata,
  input wire logic prescale_rel_wr,
  input wire logic [rtcdc_pkg::PRESCALE_W-1:0] prescale_rel_wdata,
  // Count word access
  input wire logic count_low_word_wr,
  input wire logic count_high_word_wr,
  input wire logic [rtcdc_pkg::WORD_W-1:0] count_wdata,
  input wire logic count_rel_wr,
  input wire logic [rtcdc_pkg::COUNT_W-1:0] count_rel_wdata,
  // Alarm compare
  input wire logic alarm_wr,
  input wire logic [rtcdc_pkg::COUNT_W-1:0] alarm_wdata,
  // Requests
  input wire logic [rtcdc_pkg::NUM_REQ-1:0] req_en,
  input wire logic [rtcdc_pkg::NUM_REQ-1:0] req_clr,
  // State seen by software
  output logic [rtcdc_pkg::PRESCALE_W-1:0] prescale_timer,
  output logic [rtcdc_pkg::WORD_W-1:0] count_low_word,
  output logic [rtcdc_pkg::WORD_W-1:0] count_high_word,
  output logic [rtcdc_pkg::WIDE_W-1:0] wide_count,
  output logic [rtcdc_pkg::NUM_REQ-1:0] req_flags,
  output logic rtc_irq
);

  logic [4:0] div32_q;
  logic [2:0] div8_q;
  logic [rtcdc_pkg::PRESCALE_W-1:0] pre_q;
  logic [rtcdc_pkg::PRESCALE_W-1:0] pre_rel_q;
  logic [rtcdc_pkg::COUNT_W-1:0] cnt_q;
  logic [rtcdc_pkg::COUNT_W-1:0] cnt_rel_q;
  logic [rtcdc_pkg::COUNT_W-1:0] cnt_d;
  logic [rtcdc_pkg::COUNT_W-1:0] alarm_q;
  logic [rtcdc_pkg::NUM_REQ-1:0] req_q;
  logic [rtcdc_pkg::NUM_REQ-1:0] req_set;
  logic count_tick;
  logic div32_out;
  logic div8_out;
  logic pre_ovf;
  logic [3:0] seg_ovf;
  logic alarm_hit;
  logic cnt_wr;

  // One stage step: reload on overflow, else increment
  function automatic logic [rtcdc_pkg::SEG0_W-1:0] seg_step(
    input logic [rtcdc_pkg::SEG0_W-1:0] val,
    input logic [rtcdc_pkg::SEG0_W-1:0] rel,
    input logic [rtcdc_pkg::SEG0_W-1:0] top
  );
    seg_step = (val == top) ? rel : val + 1'b1;
  endfunction

  assign count_tick = run_en & src_tick[src_sel];

  // Each fixed divider passes one pulse per full cycle, or all when bypassed
  assign div32_out = count_tick & (!div32_en | (div32_q == rtcdc_pkg::DIV32_LAST));
  assign div8_out = div32_out & (!div8_en | (div8_q == rtcdc_pkg::DIV8_LAST));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div32_q <= 5'h00;
    end else if (!div32_en) begin
      div32_q <= 5'h00;
    end else if (count_tick) begin
      div32_q <= div32_q + 5'h01;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div8_q <= 3'h0;
    end else if (!div8_en) begin
      div8_q <= 3'h0;
    end else if (div32_out) begin
      div8_q <= div8_q + 3'h1;
    end
  end

  // Prescale timer
  assign pre_ovf = div8_out & (pre_q == {rtcdc_pkg::PRESCALE_W{1'b1}});

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= rtcdc_pkg::PRESCALE_RST;
    end else if (prescale_wr) begin
      pre_q <= prescale_wdata;
    end else if (pre_ovf) begin
      pre_q <= pre_rel_q;
    end else if (div8_out) begin
      pre_q <= pre_q + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_rel_q <= rtcdc_pkg::PRESCALE_RST;
    end else if (prescale_rel_wr) begin
      pre_rel_q <= prescale_rel_wdata;
    end
  end

  // A count write swallows the step, so no carry flags and no alarm either
  assign cnt_wr = count_low_word_wr | count_high_word_wr;

  // Segment chain: each carries into the next only on its own overflow
  always_comb begin
    logic [rtcdc_pkg::SEG0_W-1:0] s0;
    logic [rtcdc_pkg::SEG0_W-1:0] s1;
    logic [rtcdc_pkg::SEG0_W-1:0] s2;
    logic [rtcdc_pkg::SEG0_W-1:0] s3;
    s0 = cnt_q[rtcdc_pkg::SEG1_LSB-1:0];
    s1 = {4'h0, cnt_q[rtcdc_pkg::SEG2_LSB-1:rtcdc_pkg::SEG1_LSB]};
    s2 = {4'h0, cnt_q[rtcdc_pkg::SEG3_LSB-1:rtcdc_pkg::SEG2_LSB]};
    s3 = cnt_q[rtcdc_pkg::COUNT_W-1:rtcdc_pkg::SEG3_LSB];
    seg_ovf[0] = pre_ovf & !cnt_wr & (s0 == 10'h3ff);
    seg_ovf[1] = seg_ovf[0] & (s1 == 10'h03f);
    seg_ovf[2] = seg_ovf[1] & (s2 == 10'h03f);
    seg_ovf[3] = seg_ovf[2] & (s3 == 10'h3ff);
    cnt_d = cnt_q;
    if (pre_ovf) begin
      cnt_d[rtcdc_pkg::SEG1_LSB-1:0] = seg_step(s0, cnt_rel_q[rtcdc_pkg::SEG1_LSB-1:0], 10'h3ff);
    end
    if (seg_ovf[0]) begin
      cnt_d[rtcdc_pkg::SEG2_LSB-1:rtcdc_pkg::SEG1_LSB] = 6'(seg_step(s1,
        {4'h0, cnt_rel_q[rtcdc_pkg::SEG2_LSB-1:rtcdc_pkg::SEG1_LSB]}, 10'h03f));
    end
    if (seg_ovf[1]) begin
      cnt_d[rtcdc_pkg::SEG3_LSB-1:rtcdc_pkg::SEG2_LSB] = 6'(seg_step(s2,
        {4'h0, cnt_rel_q[rtcdc_pkg::SEG3_LSB-1:rtcdc_pkg::SEG2_LSB]}, 10'h03f));
    end
    if (seg_ovf[2]) begin
      cnt_d[rtcdc_pkg::COUNT_W-1:rtcdc_pkg::SEG3_LSB] = seg_step(s3,
        cnt_rel_q[rtcdc_pkg::COUNT_W-1:rtcdc_pkg::SEG3_LSB], 10'h3ff);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= rtcdc_pkg::COUNT_RST;
    end else if (count_low_word_wr || count_high_word_wr) begin
      // Software write overrides a coincident count step
      if (count_low_word_wr) begin
        cnt_q[rtcdc_pkg::WORD_W-1:0] <= count_wdata;
      end
      if (count_high_word_wr) begin
        cnt_q[rtcdc_pkg::COUNT_W-1:rtcdc_pkg::WORD_W] <= count_wdata;
      end
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_rel_q <= rtcdc_pkg::COUNT_RST;
    end else if (count_rel_wr) begin
      cnt_rel_q <= count_rel_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      alarm_q <= rtcdc_pkg::COUNT_RST;
    end else if (alarm_wr) begin
      alarm_q <= alarm_wdata;
    end
  end

  // Alarm fires once, when the count steps onto the compare value
  assign alarm_hit = pre_ovf & !cnt_wr & (cnt_d == alarm_q) & (cnt_q != alarm_q);

  always_comb begin
    req_set = rtcdc_pkg::REQ_RST;
    req_set[rtcdc_pkg::REQ_PRESCALE] = pre_ovf;
    req_set[rtcdc_pkg::REQ_SEG0] = seg_ovf[0];
    req_set[rtcdc_pkg::REQ_SEG1] = seg_ovf[1];
    req_set[rtcdc_pkg::REQ_SEG2] = seg_ovf[2];
    req_set[rtcdc_pkg::REQ_SEG3] = seg_ovf[3];
    req_set[rtcdc_pkg::REQ_ALARM] = alarm_hit;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_q <= rtcdc_pkg::REQ_RST;
    end else begin
      req_q <= (req_q & ~req_clr) | req_set;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rtc_irq <= 1'b0;
    end else begin
      rtc_irq <= |(((req_q & ~req_clr) | req_set) & req_en);
    end
  end

  assign prescale_timer = pre_q;
  assign count_low_word = cnt_q[rtcdc_pkg::WORD_W-1:0];
  assign count_high_word = cnt_q[rtcdc_pkg::COUNT_W-1:rtcdc_pkg::WORD_W];
  assign wide_count = {cnt_q, pre_q};
  assign req_flags = req_q;

endmodule // rtcdc_core

// [verification/rtcdc_core_assertions.sv]
// Port level checks for the divider chain clock
module rtcdc_core_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Controls
  input wire logic [3:0] src_tick,
  input wire logic [1:0] src_sel,
  input wire logic run_en,
  input wire logic div32_en,
  input wire logic div8_en,
  input wire logic prescale_wr,
  input wire logic [15:0] prescale_wdata,
  input wire logic count_low_word_wr,
  input wire logic count_high_word_wr,
  input wire logic [15:0] count_wdata,
  input wire logic [5:0] req_en,
  input wire logic [5:0] req_clr,
  // Observed state
  input wire logic [15:0] prescale_timer,
  input wire logic [15:0] count_low_word,
  input wire logic [15:0] count_high_word,
  input wire logic [47:0] wide_count,
  input wire logic [5:0] req_flags,
  input wire logic rtc_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Direct tick into the prescaler, no write competing
  wire logic direct = run_en && src_tick[src_sel] && !div32_en && !div8_en && !prescale_wr;
  a_irq_merge: assert property (rtc_irq == |(req_flags & $past(req_en))) else $error("irq not OR of flags");
  a_low_write: assert property (count_low_word_wr |=> count_low_word == $past(count_wdata))
    else $error("low word write lost");
  a_high_write: assert property (count_high_word_wr |=> count_high_word == $past(count_wdata))
    else $error("high word write lost");
  a_pre_write: assert property (prescale_wr |=> prescale_timer == $past(prescale_wdata))
    else $error("prescaler write lost");
  a_wide_concat: assert property (wide_count == {count_high_word, count_low_word, prescale_timer})
    else $error("wide count not joined");
  a_pre_step: assert property (direct && prescale_timer != 16'hffff |=> prescale_timer == $past(prescale_timer) + 16'h1)
    else $error("prescaler did not step up");
  a_pre_ovf: assert property (direct && prescale_timer == 16'hffff |=> req_flags[0])
    else $error("prescaler overflow flag missing");
  a_idle_hold: assert property (!run_en && !prescale_wr && !count_low_word_wr && !count_high_word_wr |=> $stable(wide_count))
    else $error("count moved while stopped");
  a_flags_sticky: assert property (##1 (req_flags & $past(req_flags & ~req_clr)) == $past(req_flags & ~req_clr))
    else $error("flag dropped without clear");
endmodule // rtcdc_core_chk

// [verification/rtcdc_core_tb_top.sv]
// Self-checking bench for the divider chain clock
module rtcdc_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, reset_n = 0, run_en = 0, div32_en = 0, div8_en = 0, rtc_irq;
  logic [3:0] src_tick = 0;
  logic [1:0] src_sel = 0;
  logic [5:0] strb = 0, req_en = 0, req_clr = 0, req_flags;
  logic [15:0] prescale_timer, count_low_word, count_high_word, p;
  logic [31:0] wd32 = 0, c, d;
  logic [47:0] wide_count;
  int seed = 32'h22e8ad74, err_count = 0, checks_done = 0;
  always #50 core_clk = ~core_clk;
  rtcdc_core dut (.core_clk(core_clk), .reset_n(reset_n), .src_tick(src_tick), .src_sel(src_sel), .run_en(run_en),
    .div32_en(div32_en), .div8_en(div8_en), .prescale_wr(strb[0]), .prescale_wdata(wd32[15:0]),
    .prescale_rel_wr(strb[1]), .prescale_rel_wdata(wd32[15:0]), .count_low_word_wr(strb[2]),
    .count_high_word_wr(strb[3]), .count_wdata(wd32[15:0]), .count_rel_wr(strb[4]), .count_rel_wdata(wd32),
    .alarm_wr(strb[5]), .alarm_wdata(wd32), .req_en(req_en), .req_clr(req_clr), .prescale_timer(prescale_timer),
    .count_low_word(count_low_word), .count_high_word(count_high_word), .wide_count(wide_count),
    .req_flags(req_flags), .rtc_irq(rtc_irq));
  // Next count: a full segment takes its reload slice and carries on
  function automatic logic [31:0] seg_inc(input logic [31:0] v, input logic [31:0] r);
    int w[4] = '{10, 6, 6, 10};
    int lo = 0;
    logic [31:0] m;
    seg_inc = v;
    for (int i = 0; i < 4; i++) begin
      m = ((32'h1 << w[i]) - 32'h1) << lo;
      if ((v & m) != m) return seg_inc + (32'h1 << lo);
      seg_inc = (seg_inc & ~m) | (r & m);
      lo += w[i];
    end
  endfunction
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobe index: 0 prescaler, 1 its reload, 2 low, 3 high, 4 count reload, 5 alarm
  task automatic wr(input int k, input logic [31:0] v);
    @(posedge core_clk);
    strb <= 6'h1 << k;
    wd32 <= v;
    @(posedge core_clk);
    strb <= 6'h0;
  endtask
  // Unselected sources toggle at random so a wrong select shows up
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      src_tick <= 4'($random(seed)) | (4'h1 << src_sel);
      @(posedge core_clk);
      src_tick <= 4'($random(seed)) & ~(4'h1 << src_sel);
    end
  endtask
  task automatic clr(input logic [5:0] en);
    @(posedge core_clk);
    req_clr <= 6'h3f;
    req_en <= en;
    @(posedge core_clk);
    req_clr <= 6'h0;
  endtask
  task automatic tally_and_finish;
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    #1 chk({req_flags, rtc_irq, wide_count[40:0]}, 48'h0);
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      wr(0, d);
      wr(2, d);
      wr(3, ~d);
      #1 chk(wide_count, {~d[15:0], d[15:0], d[15:0]});
      chk({count_high_word, count_low_word}, {~d[15:0], d[15:0]});
    end
    for (int s = 0; s < 4; s++) begin
      @(posedge core_clk);
      run_en <= 1'b1;
      src_sel <= s[1:0];
      src_tick <= 4'h0;
      p = 16'($random(seed));
      p[15] = 1'b0;
      wr(0, p);
      tick(3);
      #1 chk(prescale_timer, p + 16'h3);
    end
    clr(6'h3f);
    wr(1, 32'hfffc);
    d = $random(seed);
    d[9] = 1'b0;
    wr(4, d);
    c = $random(seed);
    c[15:0] = 16'h03ff;
    wr(2, c);
    wr(3, c >> 16);
    wr(0, 32'hffff);
    c = seg_inc(c, d);
    wr(5, seg_inc(c, d));
    tick(1);
    #1 chk(wide_count, {c, 16'hfffc});
    chk({req_flags[1:0], rtc_irq}, 3'h7);
    clr(6'h0);
    #1 chk({req_flags, rtc_irq}, 7'h0);
    clr(6'h3f);
    wr(0, 32'hffff);
    tick(1);
    #1 chk(req_flags, 6'h21);
    clr(6'h3f);
    tick(3);
    #1 chk(req_flags[0], 1'b0);
    // Clear held across the overflow edge: the new flag must survive it
    @(posedge core_clk);
    req_clr <= 6'h3f;
    tick(1);
    req_clr <= 6'h0;
    #1 chk(req_flags[0], 1'b1);
    @(posedge core_clk);
    req_en <= 6'h3e;
    @(posedge core_clk);
    #1 chk({req_flags, rtc_irq}, 7'h02);
    // Every segment full: one step carries through all four
    clr(6'h3f);
    wr(2, 32'hffff);
    wr(3, 32'hffff);
    wr(0, 32'hffff);
    tick(1);
    #1 chk(wide_count, {seg_inc(32'hffff_ffff, d), 16'hfffc});
    chk(req_flags, 6'h1f);
    @(posedge core_clk);
    div8_en <= 1'b1;
    wr(0, 32'h0);
    tick(7);
    #1 chk(prescale_timer, 16'h0);
    tick(1);
    #1 chk(prescale_timer, 16'h1);
    @(posedge core_clk);
    div32_en <= 1'b1;
    tick(255);
    #1 chk(prescale_timer, 16'h1);
    tick(1);
    #1 chk(prescale_timer, 16'h2);
    @(posedge core_clk);
    reset_n <= 1'b0;
    @(posedge core_clk);
    reset_n <= 1'b1;
    #1 chk(wide_count, 48'h0);
    chk({req_flags, rtc_irq}, 7'h0);
    tally_and_finish;
  end
endmodule // rtcdc_core_tb_top
bind rtcdc_core rtcdc_core_chk chk_i (
  .core_clk(core_clk), .reset_n(reset_n), .src_tick(src_tick), .src_sel(src_sel), .run_en(run_en),
  .div32_en(div32_en), .div8_en(div8_en), .prescale_wr(prescale_wr), .prescale_wdata(prescale_wdata),
  .count_low_word_wr(count_low_word_wr), .count_high_word_wr(count_high_word_wr), .count_wdata(count_wdata),
  .req_en(req_en), .req_clr(req_clr), .prescale_timer(prescale_timer), .count_low_word(count_low_word),
  .count_high_word(count_high_word), .wide_count(wide_count), .req_flags(req_flags), .rtc_irq(rtc_irq));
